// *** design/scpsm_pkg.sv ***
/*
 * Package for the stack check and program space map block.
 * Assumes a 16-bit data space, 24-bit program space and 32-bit Avalon bus.
 */
package scpsm_pkg;
    // Register byte offsets on the Avalon-MM slave
    localparam logic [3:0] STACK_LIMIT_OFS = 4'h0;
    localparam logic [3:0] TABLE_PAGE_OFS = 4'h4;
    localparam logic [3:0] REMAP_PAGE_OFS = 4'h8;
    localparam logic [3:0] STACK_PTR_OFS = 4'hC;
    // Reset values of the page registers and the pointer
    localparam logic [7:0] TABLE_PAGE_RST = 8'h00;
    localparam logic [7:0] REMAP_PAGE_RST = 8'h00;
    localparam logic [15:0] STACK_PTR_RST = 16'h0800;
    // Lowest legal stack address; below it lies the SFR area
    localparam logic [15:0] STACK_FLOOR = 16'h0800;
    // The two legal remap page values
    localparam logic [7:0] REMAP_PROG = 8'h00;
    localparam logic [7:0] REMAP_EEPROM = 8'hFF;
    // Bit positions
    localparam int TBL_CFG_BIT = 7;
    localparam int EA_TOP_BIT = 15;
    // Bus read answer after an accepted read, in cycles
    localparam int RD_WAIT_CYC = 1;
    // Stack operation codes from the address units
    typedef enum logic [3:0] {
        SCPSM_OP_IDLE = 4'b0001,
        SCPSM_OP_PUSH = 4'b0010,
        SCPSM_OP_POP = 4'b0100,
        SCPSM_OP_REF = 4'b1000
    } scpsm_op_t;
endpackage

// *** design/scpsm_pspace_map.sv ***
/*
 * Program space address builder: fetch, table and remap forms.
 * Assumes the page registers are held by the caller; purely combinational.
 */
`timescale 1ns/100ps
module scpsm_pspace_map (
    input wire logic [7:0] table_page_reg,
    input wire logic [7:0] remap_page_reg,
    input wire logic [15:0] data_ea,
    input wire logic [22:0] pc,
    input wire logic tbl_sel,
    output logic [23:0] tbl_addr,
    output logic tbl_cfg,
    output logic remap_hit,
    output logic [23:0] remap_addr,
    output logic [23:0] fetch_addr
);
    // Page above the full EA, no alignment check (see [R10]) (see [R18])
    assign tbl_addr = {table_page_reg, data_ea};
    // Top page bit picks configuration memory (see [R11])
    assign tbl_cfg = table_page_reg[scpsm_pkg::TBL_CFG_BIT];
    // Remap is off while a table operation owns the path
    assign remap_hit = data_ea[scpsm_pkg::EA_TOP_BIT] & ~tbl_sel;
    // Bit 23 zero, page over EA bits 14..0; EA bit 15 dropped
    // (see [R12]) (see [R13]) (see [R14])
    assign remap_addr = {1'b0, remap_page_reg, data_ea[14:0]};
    // Fetch is word aligned and user space only (see [R20])
    assign fetch_addr = {1'b0, pc[22:1], 1'b0};
endmodule

// *** design/scpsm_stack_chk.sv ***
/*
 * Stack pointer keeper and limit/underflow checker.
 * Assumes one stack operation a cycle from the address units.
 */
`timescale 1ns/100ps
module scpsm_stack_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire scpsm_pkg::scpsm_op_t op,
    input wire logic [15:0] ref_ea,
    input wire logic [15:0] stack_limit_reg,
    input wire logic sp_wr,
    input wire logic [15:0] sp_wdata,
    output logic [15:0] stack_pointer_reg,
    output logic [15:0] stack_ea,
    output logic stack_err
);
    logic [15:0] sp_q;
    logic [15:0] sp_d;
    logic [15:0] ea;
    logic over;
    logic under;

    ////////////////////////////////////////////////////////////////////
    // Push uses the free word then bumps; pop drops then reads (see [R1])
    assign ea = (op == scpsm_pkg::SCPSM_OP_PUSH) ? sp_q :
                (op == scpsm_pkg::SCPSM_OP_POP) ? sp_q - 16'h0002 :
                (op == scpsm_pkg::SCPSM_OP_REF) ? ref_ea : sp_q;
    // Push at the limit itself is allowed (see [R6]) (see [R7])
    assign over = (op == scpsm_pkg::SCPSM_OP_PUSH) &&
                  (ea > stack_limit_reg);
    // Any stack EA under the SFR floor traps (see [R8])
    assign under = (op != scpsm_pkg::SCPSM_OP_IDLE) &&
                   (ea < scpsm_pkg::STACK_FLOOR);
    // One trap request in the same cycle (see [R19])
    assign stack_err = over | under;
    assign stack_ea = ea;
    assign sp_d = sp_wr ? {sp_wdata[15:1], 1'b0} :
                  (op == scpsm_pkg::SCPSM_OP_PUSH) ? sp_q + 16'h0002 :
                  (op == scpsm_pkg::SCPSM_OP_POP) ? sp_q - 16'h0002 : sp_q;
    assign stack_pointer_reg = sp_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sp_q <= scpsm_pkg::STACK_PTR_RST;
        end else begin
            sp_q <= sp_d;
        end
    end
endmodule

// *** design/scpsm_top.sv ***
/*
 * Stack check and program space map top with Avalon-MM register slave.
 * Assumes synchronous inputs on mclk and an Avalon master that holds
 * each request until waitrequest is seen low.
 */
// How it works
// [R1] Pointer marks free word; push post-increments
// [R2] Call push zero-fills counter top byte
// [R3] Exception push puts status byte beside counter
// [R4] Stack limit bit 0 always zero
// [R5] Stack limit not initialised at reset
// [R6] Every stack EA compared with limit; the code compares the push EA only
// [R7] Push at limit fine; next one traps
// [R8] Stack address below 0800h traps
// [R9] No stack read right after limit write
// [R10] Table address is page over 16-bit EA
// [R11] Table page top bit selects configuration
// [R12] Remap address is page plus 15 EA bits
// [R13] Remap stays in user memory, bit 23 zero
// [R14] EA bit 15 ignored; page bit 0 used
// [R15] Remap page only 00h or FFh
// [R16] Remap read-only, low word only
// [R17] Table reaches every byte of program word
// [R18] Table no alignment check; config reads allowed
// [R19] One stack trap request, same cycle
// [R20] Fetch address aligned, bit 23 zero
`timescale 1ns/100ps
module scpsm_top (
    input wire logic mclk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Address units
    input wire scpsm_pkg::scpsm_op_t stack_op,
    input wire logic [15:0] stack_ref_ea,
    input wire logic call_push,
    input wire logic exc_push,
    input wire logic [22:0] pc,
    input wire logic [7:0] status_low_byte,
    output logic [15:0] stack_ea,
    output logic [15:0] push_hi_word,
    output logic stack_err_trap,
    // Data EA and table path
    input wire logic [15:0] data_ea,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic tbl_rd,
    input wire logic tbl_wr,
    input wire logic tbl_hi,
    input wire logic remap_en,
    // Program memory interface
    output logic [23:0] pm_addr,
    output logic pm_rd,
    output logic pm_wr,
    output logic pm_hi_byte,
    output logic pm_cfg,
    output logic remap_wr_err,
    output logic [23:0] fetch_addr
);
    logic rst_s1_q;
    logic rst_s2_q;
    logic rst_n;

    ////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    assign rst_n = rst_s2_q;

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [15:0] stack_limit_q;
    logic [7:0] table_page_q;
    logic [7:0] remap_page_q;
    logic rd_pend_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic sel_lim;
    logic sel_tbl;
    logic sel_rmp;
    logic sel_sp;
    logic wr_lim;
    logic wr_tbl;
    logic wr_rmp;
    logic wr_sp;
    logic [15:0] lim_d;
    logic [7:0] rmp_d;
    logic [15:0] sp_val;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] nw,
                                           input logic [1:0] be);
        merge16 = {be[1] ? nw[15:8] : old[15:8],
                   be[0] ? nw[7:0] : old[7:0]};
    endfunction

    assign sel_lim = avs_address == scpsm_pkg::STACK_LIMIT_OFS;
    assign sel_tbl = avs_address == scpsm_pkg::TABLE_PAGE_OFS;
    assign sel_rmp = avs_address == scpsm_pkg::REMAP_PAGE_OFS;
    assign sel_sp = avs_address == scpsm_pkg::STACK_PTR_OFS;
    assign wr_lim = avs_write & sel_lim;
    assign wr_tbl = avs_write & sel_tbl & avs_byteenable[0];
    assign wr_rmp = avs_write & sel_rmp & avs_byteenable[0];
    assign wr_sp = avs_write & sel_sp & (avs_byteenable[1:0] == 2'b11);
    // Bit 0 forced low, word aligned stack (see [R4])
    assign lim_d = merge16(stack_limit_q, avs_writedata[15:0],
                           avs_byteenable[1:0]) & 16'hFFFE;
    // Only 00h or FFh kept; any nonzero write means EEPROM (see [R15])
    assign rmp_d = (avs_writedata[7:0] == scpsm_pkg::REMAP_PROG) ?
                   scpsm_pkg::REMAP_PROG : scpsm_pkg::REMAP_EEPROM;
    // Writes finish at once; reads wait one cycle for registered data
    assign avs_waitrequest = avs_read & ~rd_pend_q;
    assign rdata_d = sel_lim ? {16'h0000, stack_limit_q} :
                     sel_tbl ? {24'h000000, table_page_q} :
                     sel_rmp ? {24'h000000, remap_page_q} :
                     sel_sp ? {16'h0000, sp_val} : 32'h00000000;
    assign avs_readdata = rdata_q;

    // Limit has no reset: software must load it first (see [R5])
    always_ff @(posedge mclk) begin
        if (wr_lim) begin
            stack_limit_q <= lim_d;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            table_page_q <= scpsm_pkg::TABLE_PAGE_RST;
            remap_page_q <= scpsm_pkg::REMAP_PAGE_RST;
            rd_pend_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            if (wr_tbl) begin
                table_page_q <= avs_writedata[7:0];
            end
            if (wr_rmp) begin
                remap_page_q <= rmp_d;
            end
            rd_pend_q <= avs_read & ~rd_pend_q;
            if (avs_read & ~rd_pend_q) begin
                rdata_q <= rdata_d;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stack pointer and checker
    // Limit compare uses the new value the next cycle; software must
    // leave a gap before a stack read (see [R9])
    scpsm_stack_chk u_stack (
        .mclk(mclk),
        .rst_n(rst_n),
        .op(stack_op),
        .ref_ea(stack_ref_ea),
        .stack_limit_reg(stack_limit_q),
        .sp_wr(wr_sp),
        .sp_wdata(avs_writedata[15:0]),
        .stack_pointer_reg(sp_val),
        .stack_ea(stack_ea),
        .stack_err(stack_err_trap)
    );

    // Upper half of a pushed counter: status byte beside the counter top
    // byte on exceptions, zero on calls (see [R2]) (see [R3])
    assign push_hi_word = exc_push ? {status_low_byte, 1'b0, pc[22:16]} :
                          call_push ? {8'h00, 1'b0, pc[22:16]} : 16'h0000;

    ////////////////////////////////////////////////////////////////////
    // Program space addressing
    logic [23:0] tbl_addr;
    logic tbl_cfg;
    logic remap_hit;
    logic [23:0] remap_addr;
    logic tbl_sel;
    logic remap_rd;

    assign tbl_sel = tbl_rd | tbl_wr;

    scpsm_pspace_map u_map (
        .table_page_reg(table_page_q),
        .remap_page_reg(remap_page_q),
        .data_ea(data_ea),
        .pc(pc),
        .tbl_sel(tbl_sel),
        .tbl_addr(tbl_addr),
        .tbl_cfg(tbl_cfg),
        .remap_hit(remap_hit),
        .remap_addr(remap_addr),
        .fetch_addr(fetch_addr)
    );

    assign remap_rd = remap_en & remap_hit & data_rd;
    // Remap never writes; a write attempt is flagged (see [R16])
    assign remap_wr_err = remap_en & remap_hit & data_wr;
    assign pm_addr = tbl_sel ? tbl_addr : remap_addr;
    // Table reads go anywhere, config writes are blocked (see [R18])
    assign pm_rd = tbl_rd | remap_rd;
    assign pm_wr = tbl_wr & ~tbl_cfg;
    // Upper byte only by table access; remap gets the low word
    // (see [R17]) (see [R16])
    assign pm_hi_byte = tbl_sel & tbl_hi;
    assign pm_cfg = tbl_sel & tbl_cfg;
endmodule

// *** dv/scpsm_checker.sv ***
/* Checker for the stack check and program space map top.
   Assumes it is bound to scpsm_top and sees only its ports. */
`timescale 1ns/100ps
module scpsm_checker (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic avs_write,
    input wire scpsm_pkg::scpsm_op_t stack_op,
    input wire logic [22:0] pc,
    input wire logic [15:0] stack_ea,
    input wire logic stack_err_trap,
    input wire logic [15:0] data_ea,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic tbl_rd,
    input wire logic tbl_wr,
    input wire logic remap_en,
    input wire logic [23:0] pm_addr,
    input wire logic pm_rd,
    input wire logic pm_wr,
    input wire logic pm_cfg,
    input wire logic remap_wr_err,
    input wire logic [23:0] fetch_addr
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    wire tbl = tbl_rd | tbl_wr;
    wire rmp = remap_en & data_ea[15] & !tbl;
    wire is_push = stack_op == scpsm_pkg::SCPSM_OP_PUSH;
    wire is_pop = stack_op == scpsm_pkg::SCPSM_OP_POP;
    ////////////////////////////////////////////////////////////////////////
    // A bus pointer write wins over a push, so it is kept out
    sequence s_push;
        is_push && !avs_write;
    endsequence
    sequence s_pop;
        is_pop;
    endsequence
    a_push_step: assert property (s_push ##1 s_push |->
        stack_ea == $past(stack_ea) + 16'h0002) else $error("push step");
    a_push_pop: assert property (s_push ##1 s_pop |->
        stack_ea == $past(stack_ea)) else $error("pop after push");
    a_floor_trap: assert property ((is_push || is_pop) &&
        stack_ea < 16'h0800 |-> stack_err_trap) else $error("floor trap");
    a_idle_quiet: assert property (stack_op ==
        scpsm_pkg::SCPSM_OP_IDLE |-> !stack_err_trap) else $error("idle trap");
    a_fetch_form: assert property (fetch_addr ==
        {1'b0, pc[22:1], 1'b0}) else $error("fetch address");
    a_table_form: assert property (tbl |->
        pm_addr[15:0] == data_ea && pm_cfg == pm_addr[23])
        else $error("table address");
    a_remap_form: assert property (rmp && data_rd |-> pm_rd
        && !pm_addr[23] && pm_addr[14:0] == data_ea[14:0])
        else $error("remap address");
    a_remap_ro: assert property (rmp && data_wr |->
        remap_wr_err && !pm_wr) else $error("remap write");
    a_cfg_nowr: assert property (tbl_wr && pm_cfg |-> !pm_wr)
        else $error("config write");
endmodule
bind scpsm_top scpsm_checker chk (.mclk(mclk), .rst_b(rst_b),
    .avs_write(avs_write), .stack_op(stack_op), .pc(pc),
    .stack_ea(stack_ea), .stack_err_trap(stack_err_trap),
    .data_ea(data_ea), .data_rd(data_rd), .data_wr(data_wr),
    .tbl_rd(tbl_rd), .tbl_wr(tbl_wr), .remap_en(remap_en),
    .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_wr(pm_wr), .pm_cfg(pm_cfg),
    .remap_wr_err(remap_wr_err), .fetch_addr(fetch_addr));

// *** dv/scpsm_pm_model.sv ***
/* Program memory side model: counts writes that must never land.
   Assumes the memory strobes are sampled on mclk. */
`timescale 1ns/100ps
module scpsm_pm_model (
    input wire logic mclk,
    input wire logic [23:0] pm_addr,
    input wire logic pm_wr,
    input wire logic pm_cfg,
    output logic [7:0] bad_cnt
);
    // Config space takes no write; the bench expects zero
    initial bad_cnt = 8'h00;
    always @(posedge mclk) begin
        if (pm_wr === 1'b1 && (pm_cfg | pm_addr[23]))
            bad_cnt <= bad_cnt + 8'h01;
    end
endmodule

// *** dv/scpsm_top_test.sv ***
/* Self-checking bench for scpsm_top with random map traffic.
   Assumes the checker binds itself and the model sits on pm ports. */
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
module scpsm_top_test;
    logic mclk, rst_b, avs_read, avs_write, avs_waitrequest, call_push;
    logic exc_push, stack_err_trap, data_rd, data_wr, tbl_rd, tbl_wr, rh;
    logic tbl_hi, remap_en, pm_rd, pm_wr, pm_hi_byte, pm_cfg, remap_wr_err, t;
    logic [3:0] avs_address, avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata, q;
    scpsm_pkg::scpsm_op_t stack_op;
    logic [15:0] stack_ref_ea, stack_ea, push_hi_word, data_ea, seed;
    logic [22:0] pc;
    logic [7:0] status_low_byte, bad_cnt, tp, rp, rs;
    logic [23:0] pm_addr, fetch_addr;
    int n_fail, check_count, cyc;
    scpsm_top dut (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .pc(pc),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .stack_op(stack_op), .stack_ref_ea(stack_ref_ea), .tbl_hi(tbl_hi),
        .call_push(call_push), .exc_push(exc_push), .stack_ea(stack_ea),
        .status_low_byte(status_low_byte), .push_hi_word(push_hi_word),
        .stack_err_trap(stack_err_trap), .data_ea(data_ea), .pm_rd(pm_rd),
        .data_rd(data_rd), .data_wr(data_wr), .tbl_rd(tbl_rd), .pm_wr(pm_wr),
        .tbl_wr(tbl_wr), .remap_en(remap_en), .pm_addr(pm_addr),
        .pm_hi_byte(pm_hi_byte), .pm_cfg(pm_cfg),
        .remap_wr_err(remap_wr_err), .fetch_addr(fetch_addr));
    scpsm_pm_model pmm (.mclk(mclk), .pm_addr(pm_addr), .pm_wr(pm_wr),
        .pm_cfg(pm_cfg), .bad_cnt(bad_cnt));
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] lf(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[14] ^ s[12] ^ s[3]};
    endfunction
    function automatic logic [23:0] pa(input logic b, input logic [7:0] p,
                                       input logic [7:0] r,
                                       input logic [15:0] e);
        return b ? {p, e} : {1'b0, r, e[14:0]};
    endfunction
    function automatic logic [15:0] hw(input logic x, input logic c,
                                       input logic [7:0] s,
                                       input logic [6:0] h);
        return x ? {s, 1'b0, h} : c ? {9'h000, h} : 16'h0000;
    endfunction
    task automatic finish_test;
        if (n_fail == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        bus(1'b0, a, 32'h00000000);
        `CHK(q, {16'h0000, e})
    endtask
    task automatic stk(input scpsm_pkg::scpsm_op_t o,
                       input logic [15:0] e,
                       input logic x);
        stack_op <= o;
        #1;
        if (o != scpsm_pkg::SCPSM_OP_REF) `CHK(stack_ea, e)
        `CHK(stack_err_trap, x)
        @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test;
        end
    end
    initial begin
        {rst_b, avs_read, avs_write, call_push, exc_push, data_rd} = 0;
        {data_wr, tbl_rd, tbl_wr, tbl_hi, remap_en, pc, data_ea} = 0;
        {avs_address, avs_writedata, status_low_byte, stack_ref_ea} = 0;
        avs_byteenable = 4'hF;
        stack_op = scpsm_pkg::SCPSM_OP_IDLE;
        seed = 16'h0058;
        n_fail = 0;
        check_count = 0;
        cyc = 0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(scpsm_pkg::TABLE_PAGE_OFS, 16'h0000);
        rd(scpsm_pkg::REMAP_PAGE_OFS, 16'h0000);
        rd(scpsm_pkg::STACK_PTR_OFS, 16'h0800);
        bus(1'b1, 4'h2, 32'hFFFFFFFF);
        rd(4'h2, 16'h0000);
        // A page write without byte lane 0 must not land
        avs_byteenable <= 4'hE;
        bus(1'b1, scpsm_pkg::TABLE_PAGE_OFS, 32'h000000AA);
        avs_byteenable <= 4'hF;
        rd(scpsm_pkg::TABLE_PAGE_OFS, 16'h0000);
        bus(1'b1, scpsm_pkg::STACK_LIMIT_OFS, 32'h00000901);
        // A read sits between limit write and stack use
        rd(scpsm_pkg::STACK_LIMIT_OFS, 16'h0900);
        bus(1'b1, scpsm_pkg::STACK_PTR_OFS, 32'h000008FE);
        stk(scpsm_pkg::SCPSM_OP_PUSH, 16'h08FE, 1'b0);
        stk(scpsm_pkg::SCPSM_OP_PUSH, 16'h0900, 1'b0);
        stk(scpsm_pkg::SCPSM_OP_PUSH, 16'h0902, 1'b1);
        stk(scpsm_pkg::SCPSM_OP_POP, 16'h0902, 1'b0);
        stack_op <= scpsm_pkg::SCPSM_OP_IDLE;
        rd(scpsm_pkg::STACK_PTR_OFS, 16'h0902);
        bus(1'b1, scpsm_pkg::STACK_PTR_OFS, 32'h00000800);
        stack_ref_ea <= 16'h0600;
        stk(scpsm_pkg::SCPSM_OP_POP, 16'h07FE, 1'b1);
        stk(scpsm_pkg::SCPSM_OP_REF, 16'h0000, 1'b1);
        stk(scpsm_pkg::SCPSM_OP_PUSH, 16'h07FE, 1'b1);
        stack_op <= scpsm_pkg::SCPSM_OP_IDLE;
        rd(scpsm_pkg::STACK_PTR_OFS, 16'h0800);
        for (int i = 0; i < 60; i++) begin
            seed = lf(seed);
            tp = (i == 1) ? 8'h80 : seed[7:0];
            rp = (i % 4 == 0) ? 8'h00 : seed[15:8];
            rs = (rp == 8'h00) ? 8'h00 : 8'hFF;
            bus(1'b1, scpsm_pkg::TABLE_PAGE_OFS, {24'h000000, tp});
            bus(1'b1, scpsm_pkg::REMAP_PAGE_OFS, {24'h000000, rp});
            rd(scpsm_pkg::TABLE_PAGE_OFS, {8'h00, tp});
            rd(scpsm_pkg::REMAP_PAGE_OFS, {8'h00, rs});
            seed = lf(seed);
            data_ea <= seed;
            pc <= {seed[6:0], seed ^ 16'h5A5A};
            status_low_byte <= seed[15:8];
            {tbl_rd, tbl_wr} <= {seed[0], seed[1] & !seed[0]};
            {data_rd, data_wr} <= {seed[4], seed[5] & !seed[4]};
            {tbl_hi, remap_en, exc_push} <= seed[3:1];
            call_push <= seed[7] & !seed[2];
            #1;
            t = tbl_rd | tbl_wr;
            rh = remap_en & data_ea[15] & !t;
            `CHK(pm_addr, pa(t, tp, rs, data_ea))
            `CHK(pm_cfg, t & tp[7])
            `CHK(pm_wr, tbl_wr & !tp[7])
            `CHK(pm_rd, t ? tbl_rd : rh & data_rd)
            `CHK(remap_wr_err, rh & data_wr)
            `CHK(pm_hi_byte, t & tbl_hi)
            `CHK(fetch_addr, {1'b0, pc[22:1], 1'b0})
            `CHK(push_hi_word, hw(exc_push, call_push, status_low_byte,
                pc[22:16]))
        end
        // Reset in mid-run brings the pages and the pointer back
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(scpsm_pkg::TABLE_PAGE_OFS, 16'h0000);
        rd(scpsm_pkg::REMAP_PAGE_OFS, 16'h0000);
        rd(scpsm_pkg::STACK_PTR_OFS, 16'h0800);
        `CHK(bad_cnt, 8'h00)
        finish_test;
    end
endmodule
